// ===== adtc_top.sv
// conversion trigger, transfer and register control of the acquisition card
`timescale 1ns/1ps
`default_nettype none
`include "adtc_consts.svh"

module adtc_top (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // host i/o bus
   input  wire logic [5:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_wdata,
   output logic      [15:0] o_rdata,
   output logic             o_irq,
   // converter and front end
   output logic             o_adc_start,
   input  wire logic        i_adc_done,
   input  wire logic [11:0] i_adc_data,
   output logic      [4:0]  o_adc_chan,
   output logic      [1:0]  o_adc_gain,
   input  wire logic        i_single_ended,
   // external trigger and digital i/o pins
   input  wire logic        i_ext_trig,
   input  wire logic [15:0] i_di,
   output logic      [15:0] o_do,
   // timer outputs
   output logic      [2:0]  o_tmr_out
);
   import adtc_pkg::*;

   adtc_pkg::adtc_top_s s;
   adtc_pkg::adtc_top_s next_s;
   logic [2:0][15:0]    t_count;
   logic [2:0]          t_out;
   logic [2:0]          t_en;
   logic                wr_sw;
   logic                ext_fall;
   logic [2:0]          t_fall;
   logic                trig_sel;
   logic                accept;
   logic                push_done;
   logic                irq_event;

   adtc_stream_if #(.W(16)) res_if ();

   ////////////////////////////////////////////////////////////////////////
   // interval timers and result fifo

   // timer 1 also runs on its own while a pre/post window is open
   assign t_en = {s.tmr_en[2],
                  s.tmr_en[1] | (s.armed & (s.trig == TRIG_PRE || s.trig == TRIG_POST)),
                  s.tmr_en[0]};

   // three independent 16-bit timers
   for (genvar g = 0; g < 3; g++) begin : g_tmr
      adtc_timer #(.W(16)) u_tmr (
         .i_clk    (i_clk),
         .i_reset  (i_reset),
         .i_tick   (s.tick),
         .i_enable (t_en[g]),
         .i_load   (s.tmr_load[g]),
         .i_value  (s.tmr_val),
         .o_count  (t_count[g]),
         .o_out    (t_out[g])
      );
   end

   adtc_fifo #(.W(16), .D(16)) u_fifo (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .s_io    (res_if)
   );

   // fifo feed and drain
   assign res_if.in_data   = s.result;
   assign res_if.in_valid  = (s.state == ST_PUSH);
   assign res_if.out_ready = !s.hold_valid;

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_rdata     = s.rdata;
   assign o_irq       = s.irq;
   assign o_adc_start = s.start;
   assign o_adc_chan  = s.chan;
   assign o_adc_gain  = s.gain;
   assign o_do        = s.dout;
   assign o_tmr_out   = t_out;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   // events, register writes, sequencer, reads
   always_comb begin
      next_s          = s;
      next_s.start    = 1'b0;
      next_s.tmr_load = 3'h0;
      next_s.t_prev   = t_out;
      // pin synchronisers
      next_s.ext_sy   = {s.ext_sy[1:0], i_ext_trig};
      next_s.done_sy  = {s.done_sy[1:0], i_adc_done};
      next_s.type_sy  = {s.type_sy[0], i_single_ended};
      next_s.di_s1    = i_di;
      next_s.di_s2    = s.di_s1;
      next_s.data_s1  = i_adc_data;
      next_s.data_s2  = s.data_s1;
      // timer input clock divider
      next_s.tick     = (s.tick_cnt == 6'(`ADTC_TMR_DIV - 1));
      next_s.tick_cnt = next_s.tick ? 6'h00 : s.tick_cnt + 6'h01;
      // edge events
      ext_fall  = s.ext_sy[2] & !s.ext_sy[1];
      t_fall    = s.t_prev & ~t_out;
      wr_sw     = i_wr && (i_addr == `ADTC_OFS_SWTRIG);
      push_done = res_if.in_valid && res_if.in_ready;
      // pre/post windows
      if (ext_fall && s.trig == TRIG_PRE) begin
         next_s.armed = 1'b0;
      end else if (ext_fall && s.trig == TRIG_POST) begin
         next_s.armed = 1'b1;
      end
      // only the selected source may trigger
      case (s.trig)
         TRIG_GENERAL:  trig_sel = wr_sw | t_fall[0];
         TRIG_EXTERNAL: trig_sel = ext_fall;
         TRIG_PRE:      trig_sel = t_fall[1] & s.armed;
         TRIG_POST:     trig_sel = t_fall[1] & s.armed;
         default:       trig_sel = 1'b0;
      endcase
      // triggers while busy or with a full fifo are dropped
      accept = trig_sel && (s.state == ST_IDLE) && res_if.in_ready;
      // host writes
      if (i_wr) begin
         case (i_addr)
            `ADTC_OFS_TMR0:    next_s.tmr_load = 3'h1;
            `ADTC_OFS_TMR1:    next_s.tmr_load = 3'h2;
            `ADTC_OFS_TMR2:    next_s.tmr_load = 3'h4;
            `ADTC_OFS_TMR_CTL: next_s.tmr_en = i_wdata[2:0];
            // differential input keeps only four channel bits
            `ADTC_OFS_STATUS:  next_s.chan = s.type_sy[1] ? i_wdata[4:0]
                                                          : {1'b0, i_wdata[3:0]};
            `ADTC_OFS_GAIN:    next_s.gain = i_wdata[1:0];
            `ADTC_OFS_MODE: begin
               next_s.trig    = adtc_trig_e'(i_wdata[`ADTC_MODE_TRIG_LSB +: 2]);
               next_s.irq_src = i_wdata[`ADTC_MODE_IRQ_LSB +: 3];
               next_s.armed   = (i_wdata[1:0] == 2'h2);
            end
            `ADTC_OFS_DIO:     next_s.dout = i_wdata;
            default:           next_s.tmr_val = s.tmr_val;
         endcase
         next_s.tmr_val = i_wdata;
      end
      // conversion sequencer
      case (s.state)
         ST_IDLE: begin
            if (accept) begin
               next_s.state    = ST_CONV;
               next_s.start    = 1'b1;
               next_s.ready    = 1'b0;
               next_s.cap_chan = s.chan[3:0];
            end
         end
         ST_CONV: begin
            if (s.done_sy[1] && !s.done_sy[2]) begin
               next_s.result = {s.cap_chan, s.data_s2};
               next_s.state  = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (push_done) begin
               next_s.state = ST_IDLE;
            end
         end
         default: next_s.state = ST_IDLE;
      endcase
      // holding register drains the fifo; a result read frees it
      if (i_rd && i_addr == `ADTC_OFS_RESULT) begin
         next_s.hold_valid = 1'b0;
      end
      if (res_if.out_valid && !s.hold_valid) begin
         next_s.hold       = res_if.out_data;
         next_s.hold_valid = 1'b1;
      end
      // ready only once idle with a latched result
      if (!accept && next_s.state == ST_IDLE && next_s.hold_valid) begin
         next_s.ready = 1'b1;
      end
      // interrupt source decode; set wins over the clearing read
      case (s.irq_src)
         IRQ_DONE:   irq_event = push_done;
         IRQ_PACER0: irq_event = t_fall[0];
         IRQ_EXT:    irq_event = ext_fall;
         IRQ_PACER1: irq_event = t_fall[1];
         default:    irq_event = 1'b0;
      endcase
      if (i_rd && i_addr == `ADTC_OFS_SWTRIG) begin
         next_s.irq = 1'b0;
      end
      if (irq_event) begin
         next_s.irq = 1'b1;
      end
      // registered read data
      if (i_rd) begin
         case (i_addr)
            `ADTC_OFS_TMR0:   next_s.rdata = t_count[0];
            `ADTC_OFS_TMR1:   next_s.rdata = t_count[1];
            `ADTC_OFS_TMR2:   next_s.rdata = t_count[2];
            `ADTC_OFS_STATUS: next_s.rdata = {8'h00, s.gain, t_out[1], t_out[0], t_out[2],
                                              1'b0, s.type_sy[1], s.ready};
            `ADTC_OFS_DIO:    next_s.rdata = s.di_s2;
            `ADTC_OFS_RESULT: next_s.rdata = s.hold;
            default:          next_s.rdata = 16'h0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s            <= '0;
         s.trig       <= adtc_trig_e'(`ADTC_TRIG_RST);
         s.irq_src    <= `ADTC_IRQ_RST;
         s.gain       <= `ADTC_GAIN_RST;
         s.chan       <= `ADTC_CHAN_RST;
         s.dout       <= `ADTC_DOUT_RST;
         s.tmr_en     <= `ADTC_TMR_EN_RST;
         s.t_prev     <= 3'h7;
         s.ready      <= 1'b1;
         s.ext_sy     <= 3'h7;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence seq_accept;
      s.state == ST_IDLE && trig_sel && res_if.in_ready;
   endsequence

   sequence seq_start_then_busy;
      s.start && !s.ready && s.state == ST_CONV;
   endsequence

   a_sw_trig_start: assert property (
      (i_wr && i_addr == `ADTC_OFS_SWTRIG && s.trig == TRIG_GENERAL
       && s.state == ST_IDLE && res_if.in_ready) |=> s.start)
      else $error("software trigger did not start a conversion");

   a_accept_clears_ready: assert property (seq_accept |=> seq_start_then_busy)
      else $error("accepted trigger did not clear ready");

   a_busy_not_ready: assert property (s.state != ST_IDLE |-> !s.ready)
      else $error("ready high while converting");

   a_unselected_ignored: assert property (!trig_sel |=> !s.start)
      else $error("conversion started without selected source");

   a_ext_fall_start: assert property (
      (s.trig == TRIG_EXTERNAL && s.state == ST_IDLE && res_if.in_ready
       && $fell(s.ext_sy[1])) |=> s.start)
      else $error("external falling edge ignored");

   a_ext_level_none: assert property (
      (s.trig == TRIG_EXTERNAL && !ext_fall) |=> !s.start)
      else $error("external level started a conversion");

   a_done_irq: assert property (
      (s.irq_src == IRQ_DONE && s.state == ST_PUSH && res_if.in_ready) |=> s.irq)
      else $error("no interrupt on conversion done");

   a_no_src_quiet: assert property (
      (s.irq_src == IRQ_NONE && !s.irq) |=> !s.irq)
      else $error("interrupt raised with no source");

   a_result_format: assert property (
      (s.state == ST_CONV && s.done_sy[1] && !s.done_sy[2])
      |=> s.result == {$past(s.cap_chan), $past(s.data_s2)})
      else $error("result word format wrong");

   a_gain_write: assert property (
      (i_wr && i_addr == `ADTC_OFS_GAIN) |=> o_adc_gain == $past(i_wdata[1:0]))
      else $error("gain code not updated");

   a_do_write: assert property (
      (i_wr && i_addr == `ADTC_OFS_DIO) |=> o_do == $past(i_wdata))
      else $error("digital output not updated");

   a_mode_decode: assert property (
      (i_wr && i_addr == `ADTC_OFS_MODE)
      |=> s.trig == $past(i_wdata[1:0]) && s.irq_src == $past(i_wdata[4:2]))
      else $error("mode fields not stored");
endmodule

`default_nettype wire

// ===== adtc_consts.svh
// offsets, field positions, reset values and timing counts of the conversion control block
`ifndef ADTC_CONSTS_SVH
`define ADTC_CONSTS_SVH

// register byte offsets in the 64-byte i/o window
`define ADTC_OFS_TMR0      6'h00
`define ADTC_OFS_TMR1      6'h04
`define ADTC_OFS_TMR2      6'h08
`define ADTC_OFS_TMR_CTL   6'h0C
`define ADTC_OFS_STATUS    6'h10
`define ADTC_OFS_GAIN      6'h14
`define ADTC_OFS_MODE      6'h18
`define ADTC_OFS_SWTRIG    6'h1C
`define ADTC_OFS_DIO       6'h20
`define ADTC_OFS_RESULT    6'h30

// field positions
`define ADTC_MODE_TRIG_LSB 0
`define ADTC_MODE_IRQ_LSB  2
`define ADTC_RES_CHAN_LSB  12

// reset values
`define ADTC_TRIG_RST      2'h0
`define ADTC_IRQ_RST       3'h0
`define ADTC_GAIN_RST      2'h0
`define ADTC_CHAN_RST      5'h00
`define ADTC_DOUT_RST      16'h0000
`define ADTC_TMR_EN_RST    3'h0

// timing: system clock and interval timer input clock
`define ADTC_CLK_NS        5
`define ADTC_TMR_CLK_NS    250
`define ADTC_TMR_DIV       ((`ADTC_TMR_CLK_NS) / (`ADTC_CLK_NS))

`endif

// ===== adtc_pkg.sv
// types shared by the conversion control block
package adtc_pkg;

   // trigger method, in mode register order
   typedef enum logic [1:0] {
      TRIG_GENERAL,
      TRIG_EXTERNAL,
      TRIG_PRE,
      TRIG_POST
   } adtc_trig_e;

   // interrupt source codes; other codes mean none
   typedef enum logic [2:0] {
      IRQ_NONE,
      IRQ_DONE,
      IRQ_PACER0,
      IRQ_EXT,
      IRQ_PACER1
   } adtc_irq_e;

   // conversion sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_PUSH
   } adtc_state_e;

   // all state of the top module
   typedef struct packed {
      adtc_state_e state;
      adtc_trig_e  trig;
      logic [2:0]  irq_src;
      logic [1:0]  gain;
      logic [4:0]  chan;
      logic [15:0] dout;
      logic [2:0]  tmr_en;
      logic [2:0]  tmr_load;
      logic [15:0] tmr_val;
      logic [2:0]  t_prev;
      logic        armed;
      logic        start;
      logic        ready;
      logic        irq;
      logic [3:0]  cap_chan;
      logic [15:0] result;
      logic [15:0] hold;
      logic        hold_valid;
      logic [15:0] rdata;
      logic [5:0]  tick_cnt;
      logic        tick;
      logic [2:0]  ext_sy;
      logic [2:0]  done_sy;
      logic [1:0]  type_sy;
      logic [15:0] di_s1;
      logic [15:0] di_s2;
      logic [11:0] data_s1;
      logic [11:0] data_s2;
   } adtc_top_s;

endpackage

// ===== adtc_stream_if.sv
// valid/ready word stream between the sequencer and the result fifo
`timescale 1ns/1ps
`default_nettype none

interface adtc_stream_if #(parameter int W = 16);
   logic [W-1:0] in_data;
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] out_data;
   logic         out_valid;
   logic         out_ready;

   modport fifo (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
   modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

`default_nettype wire

// ===== adtc_fifo.sv
// result fifo, flip-flop storage, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module adtc_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_reset,
   // stream
   adtc_stream_if.fifo s_io
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [CW-1:0]       cnt;
   } adtc_fifo_s;

   adtc_fifo_s s;
   adtc_fifo_s next_s;
   logic       push;
   logic       pop;

   // honest full and empty from the fill count
   assign s_io.in_ready  = (s.cnt != CW'(D));
   assign s_io.out_valid = (s.cnt != '0);
   assign s_io.out_data  = s.mem[s.rp];

   // pointer and count update
   always_comb begin
      next_s = s;
      push   = s_io.in_valid && s_io.in_ready;
      pop    = s_io.out_valid && s_io.out_ready;
      if (push) begin
         next_s.mem[s.wp] = s_io.in_data;
         next_s.wp        = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + CW'(1);
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - CW'(1);
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

`default_nettype wire

// ===== adtc_timer.sv
// 16-bit interval timer, rate-generator style, counts on a tick enable
`timescale 1ns/1ps
`default_nettype none

module adtc_timer #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   // control
   input  wire logic         i_tick,
   input  wire logic         i_enable,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_value,
   // state
   output logic      [W-1:0] o_count,
   output logic              o_out
);
   typedef struct packed {
      logic [W-1:0] count;
      logic [W-1:0] reload;
      logic         out;
   } adtc_timer_s;

   adtc_timer_s s;
   adtc_timer_s next_s;

   assign o_count = s.count;
   assign o_out   = s.out;

   // load, then count down; output dips low for one tick per period
   always_comb begin
      next_s = s;
      if (i_load) begin
         next_s.reload = i_value;
         next_s.count  = i_value;
         next_s.out    = 1'b1;
      end else if (i_enable && i_tick) begin
         if (s.count <= W'(1)) begin
            next_s.count = s.reload;
            next_s.out   = 1'b0;
         end else begin
            next_s.count = s.count - W'(1);
            next_s.out   = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s <= '{count: '0, reload: '0, out: 1'b1};
      end else begin
         s <= next_s;
      end
   end
endmodule

`default_nettype wire

// ===== adtc_adc_model.sv
// behavioural converter standing on the far side of the start/done pins
`timescale 1ns/1ps
`default_nettype none

module adtc_adc_model #(
   parameter int LAT = 20
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // converter pins
   input  wire logic        i_start,
   input  wire logic [11:0] i_sample,
   output logic             o_done,
   output logic      [11:0] o_data
);
   int cnt;

   // start drops done, data churns until valid, done rises two cycles later
   always @(posedge i_clk) begin
      if (i_reset) begin
         cnt    <= 0;
         o_done <= 1'b0;
         o_data <= 12'hA5A;
      end else if (i_start) begin
         cnt    <= LAT;
         o_done <= 1'b0;
         o_data <= ~o_data; // not yet valid
      end else if (cnt > 1) begin
         cnt    <= cnt - 1;
         o_data <= (cnt == 3) ? i_sample : ((cnt > 3) ? ~o_data : o_data);
      end else if (cnt == 1) begin
         cnt    <= 0;
         o_done <= 1'b1; // data already stable
      end
   end
endmodule

`default_nettype wire

// ===== adtc_tb.sv
// self-checking testbench of the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "adtc_consts.svh"

module testbench;
   import adtc_pkg::*;

   logic        i_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic [5:0]  i_addr = 6'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] i_wdata = 16'h0000;
   logic [15:0] o_rdata;
   logic        o_irq;
   logic        o_adc_start;
   logic        adc_done;
   logic [11:0] adc_data;
   logic [4:0]  o_adc_chan;
   logic [1:0]  o_adc_gain;
   logic        i_single_ended = 1'b1;
   logic        i_ext_trig = 1'b1;
   logic [15:0] i_di = 16'h0000;
   logic [15:0] o_do;
   logic [2:0]  o_tmr_out;
   logic [11:0] sample = 12'h000;
   logic [15:0] rv;
   int          miscompares = 0;
   int          check_count = 0;
   int          starts = 0;

   ////////////////////////////////////////
   adtc_top u_dut (
      .i_clk          (i_clk),
      .i_reset        (i_reset),
      .i_addr         (i_addr),
      .i_wr           (i_wr),
      .i_rd           (i_rd),
      .i_wdata        (i_wdata),
      .o_rdata        (o_rdata),
      .o_irq          (o_irq),
      .o_adc_start    (o_adc_start),
      .i_adc_done     (adc_done),
      .i_adc_data     (adc_data),
      .o_adc_chan     (o_adc_chan),
      .o_adc_gain     (o_adc_gain),
      .i_single_ended (i_single_ended),
      .i_ext_trig     (i_ext_trig),
      .i_di           (i_di),
      .o_do           (o_do),
      .o_tmr_out      (o_tmr_out)
   );

   adtc_adc_model #(.LAT(20)) u_adc (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_start  (o_adc_start),
      .i_sample (sample),
      .o_done   (adc_done),
      .o_data   (adc_data)
   );

   // 200 mhz clock
   always #2.5 i_clk = ~i_clk;

   // count start pulses
   always @(posedge i_clk) begin
      if (o_adc_start === 1'b1) starts <= starts + 1;
   end

   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(posedge i_clk);
      #1;
      i_wr = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge i_clk);
      #1;
      i_addr = a;
      i_rd = 1'b1;
      @(posedge i_clk);
      #1;
      i_rd = 1'b0;
      d = o_rdata;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      rd(`ADTC_OFS_STATUS, rv);
      while (rv[0] !== 1'b1 && n < 100) begin
         rd(`ADTC_OFS_STATUS, rv);
         n++;
      end
      chk("ready", 16'h0001, {15'h0000, rv[0]});
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   ////////////////////////////////////////
   task automatic t_reset();
      chk("chan", 16'h0000, {11'h000, o_adc_chan});
      chk("do", 16'h0000, o_do);
      chk("irq", 16'h0000, {15'h0000, o_irq});
      // input type strap needs two edges through its synchroniser
      cycles(2);
      rd(`ADTC_OFS_STATUS, rv);
      chk("status", 16'h003B, rv);
      rd(`ADTC_OFS_GAIN, rv);
      chk("gain read", 16'h0000, rv);
      rd(6'h3C, rv);
      chk("unmapped", 16'h0000, rv);
   endtask

   task automatic t_dio();
      wr(`ADTC_OFS_DIO, 16'hA55A);
      chk("do", 16'hA55A, o_do);
      i_di = 16'h3CC3;
      cycles(3);
      rd(`ADTC_OFS_DIO, rv);
      chk("di", 16'h3CC3, rv);
   endtask

   task automatic t_sw_poll();
      int s0;
      wr(`ADTC_OFS_TMR_CTL, 16'h0000);
      wr(`ADTC_OFS_MODE, 16'h0000);
      wr(`ADTC_OFS_STATUS, 16'h0013);
      wr(`ADTC_OFS_GAIN, 16'h0003);
      chk("chan", 16'h0013, {11'h000, o_adc_chan});
      chk("gain", 16'h0003, {14'h0000, o_adc_gain});
      cycles(4);
      sample = 12'hABC;
      s0 = starts;
      wr(`ADTC_OFS_SWTRIG, 16'h5A5A);
      rd(`ADTC_OFS_STATUS, rv);
      chk("busy", 16'h0000, {15'h0000, rv[0]});
      chk("starts", 16'h0001, 16'(starts - s0));
      wait_ready();
      rd(`ADTC_OFS_RESULT, rv);
      chk("result", 16'h3ABC, rv);
      chk("irq", 16'h0000, {15'h0000, o_irq});
      rd(`ADTC_OFS_STATUS, rv);
      chk("status gain", 16'h00C1, rv & 16'h00C1);
   endtask

   task automatic t_irq_done();
      int n;
      wr(`ADTC_OFS_MODE, 16'h0004);
      sample = 12'h123;
      wr(`ADTC_OFS_SWTRIG, 16'h0000);
      n = 0;
      while (o_irq !== 1'b1 && n < 60) begin
         cycles(1);
         n++;
      end
      chk("irq set", 16'h0001, {15'h0000, o_irq});
      rd(`ADTC_OFS_SWTRIG, rv);
      chk("irq clr", 16'h0000, {15'h0000, o_irq});
      wait_ready();
      rd(`ADTC_OFS_RESULT, rv);
      chk("result", 16'h3123, rv);
   endtask

   task automatic t_ext();
      int s0;
      wr(`ADTC_OFS_MODE, 16'h000D);
      s0 = starts;
      wr(`ADTC_OFS_SWTRIG, 16'h0001);
      cycles(8);
      chk("sw in ext", 16'h0000, 16'(starts - s0));
      sample = 12'h7E1;
      i_ext_trig = 1'b0;
      cycles(8);
      chk("ext fall", 16'h0001, 16'(starts - s0));
      chk("ext irq", 16'h0001, {15'h0000, o_irq});
      rd(`ADTC_OFS_SWTRIG, rv);
      chk("ext irq clr", 16'h0000, {15'h0000, o_irq});
      wait_ready();
      rd(`ADTC_OFS_RESULT, rv);
      chk("result", 16'h37E1, rv);
      i_ext_trig = 1'b1;
      cycles(8);
      chk("ext rise", 16'h0001, 16'(starts - s0));
      wr(`ADTC_OFS_MODE, 16'h0000);
      i_ext_trig = 1'b0;
      cycles(8);
      chk("ext in gen", 16'h0001, 16'(starts - s0));
      i_ext_trig = 1'b1;
   endtask

   task automatic t_diff();
      i_single_ended = 1'b0;
      cycles(4);
      wr(`ADTC_OFS_STATUS, 16'h001F);
      chk("diff chan", 16'h000F, {11'h000, o_adc_chan});
      rd(`ADTC_OFS_STATUS, rv);
      chk("type bit", 16'h0000, rv & 16'h0002);
      i_single_ended = 1'b1;
   endtask

   ////////////////////////////////////////
   // wait until the start counter moves, bounded
   task automatic wait_start(input int s0);
      int n;
      n = 0;
      while (starts == s0 && n < 300) begin
         cycles(1);
         n++;
      end
   endtask

   // primary pacer triggers a conversion and its fall interrupts
   task automatic t_pacer();
      int n;
      int s0;
      sample = 12'h456;
      wr(`ADTC_OFS_MODE, 16'h0008);
      wr(`ADTC_OFS_TMR0, 16'h0002);
      s0 = starts;
      wr(`ADTC_OFS_TMR_CTL, 16'h0001);
      n = 0;
      while (o_irq !== 1'b1 && n < 300) begin
         cycles(1);
         n++;
      end
      chk("pacer irq", 16'h0001, {15'h0000, o_irq});
      chk("pacer out", 16'h0000, {15'h0000, o_tmr_out[0]});
      cycles(1);
      chk("pacer start", 16'h0001, 16'(starts - s0));
      wr(`ADTC_OFS_TMR_CTL, 16'h0000);
      rd(`ADTC_OFS_SWTRIG, rv);
      chk("pacer clr", 16'h0000, {15'h0000, o_irq});
      wait_ready();
      rd(`ADTC_OFS_RESULT, rv);
      chk("pacer result", 16'hF456, rv);
   endtask

   // post window opens on the pin fall, pre window closes on it
   task automatic t_window();
      int s0;
      wr(`ADTC_OFS_TMR1, 16'h0002);
      wr(`ADTC_OFS_MODE, 16'h0003);
      s0 = starts;
      cycles(150);
      chk("post idle", 16'h0000, 16'(starts - s0));
      i_ext_trig = 1'b0;
      wait_start(s0);
      chk("post run", 16'h0001, 16'(starts - s0));
      i_ext_trig = 1'b1;
      wr(`ADTC_OFS_MODE, 16'h0002);
      s0 = starts;
      wait_start(s0);
      chk("pre run", 16'h0001, 16'(starts - s0));
      i_ext_trig = 1'b0;
      cycles(200);
      s0 = starts;
      cycles(200);
      chk("pre stop", 16'h0000, 16'(starts - s0));
      i_ext_trig = 1'b1;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      cycles(6);
      i_reset = 1'b0;
      t_reset();
      t_dio();
      t_sw_poll();
      t_irq_done();
      t_ext();
      t_diff();
      t_pacer();
      t_window();
      test_done();
   end

   // watchdog, far beyond the expected thousand or so cycles
   initial begin
      #100000;
      miscompares++;
      test_done();
   end
endmodule

`default_nettype wire
